// *** schp_host_model.sv ***
// Host bus master model that drives the port in place of the processor
`timescale 1ns/100ps
module schp_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [11:0]      paddr_out,
  output logic [31:0]      pwdata_out
);
  // Idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end
  // One access; selects and data held until pready, then a recovery gap
  // The wait has no limit of its own: only the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [10:0] wd,
                      output logic [7:0] rd, output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= adr;
    pwdata_out <= {21'h00_0000, wd};
    @(posedge clk_in);
    penable_out <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_in !== 1'b1);
    rd = prdata_in[7:0];
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // Released data lines show the inverse, never a stale copy
    pwdata_out <= ~pwdata_out;
    // Recovery spacing, rounded up to whole clocks
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// *** schp_pkg.sv ***
// Types shared by the host port design
`include "schp_regs.svh"
package schp_pkg;
  typedef struct packed {
    logic [`SCHP_CNT_W-1:0] count;
    logic [4:0]             status;
  } schp_entry_type;
  typedef enum logic [1:0] {
    SCHP_IDLE  = 2'b00,
    SCHP_FIRST = 2'b01,
    SCHP_REC   = 2'b10
  } schp_phase_type;
  typedef struct packed {
    logic       write;
    logic       chan_a;
    logic       data_sel;
    logic       ack;
    logic [7:0] wdata;
  } schp_req_type;
endpackage

// *** schp_regs.svh ***
// Register codes, field positions, reset values and timing counts for the host port
`ifndef SCHP_REGS_SVH
`define SCHP_REGS_SVH
// APB byte addresses (one word each)
`define SCHP_ADDR_BUS      12'h000
`define SCHP_ADDR_RDATA    12'h004
`define SCHP_ADDR_STATUS   12'h008
`define SCHP_ADDR_EVENT    12'h00C
`define SCHP_ADDR_VECTOR   12'h010
// Register codes
`define SCHP_REG_FLAG      4'h7
`define SCHP_REG_VECTOR    4'h2
`define SCHP_REG_MASTER    4'h9
`define SCHP_REG_IRQDMA    4'h1
`define SCHP_REG_EXT       4'hF
// Field positions
`define SCHP_EXT_ENH_BIT   0
`define SCHP_EXT_FIFO_BIT  2
`define SCHP_WREQ_FUNC_BIT 6
`define SCHP_WREQ_EN_BIT   7
`define SCHP_WREQ_RX_BIT   5
`define SCHP_DREQ_BIT      4
// Reset values
`define SCHP_EXT_RESET     8'h00
// Frame status FIFO geometry
`define SCHP_FIFO_DEPTH    10
`define SCHP_CNT_W         14
// Recovery spacing 3.5 peripheral clocks, rounded up to cycles
`define SCHP_RECOVERY_HALF_PCLK 7
`define SCHP_RECOVERY_CYC  ((`SCHP_RECOVERY_HALF_PCLK + 1) / 2)
`endif

// *** schp_top.sv ***
// Host bus port with indirect register access and per channel frame status FIFO
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "schp_regs.svh"
// Operation
// - Stall line acts as wait or request
// - Separate transmit request enables full duplex DMA
// - Pointer low five bits clear after access
// - Channel select high means A, low B
// - Data select reaches data register directly
// - Point high code selects registers 8-15
// - FIFO off: positions 4-7 mirror 0-3
// - Read effective only with chip select
// - Write data captured at strobe rise
// - Acknowledge places vector, sets service latch
// - Vector read raw on A, modified B
// - Vector and master control shared registers
// - Enhancement bit redirects flag writes
// - FIFO mode: positions 6,7 read FIFO
// - Ten by nineteen FIFO, 14-bit counter
// - Closing flag pushes count and status
// - CRC checker reset at frame end
// - Ten frames stored before overrun
// - FIFO mode: end of frame never locks
// - FIFO active only enabled and SDLC
// - Reset clears FIFO enable
// - Readback bit 2 shows FIFO enable
// - End of frame bit reads one while the FIFO holds an entry
// - Status read pops, no underflow
// - Overflow flag until enable toggled
module schp_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [1:0]  sdlc_mode_in,
  input  wire logic [1:0]  rx_byte_in,
  input  wire logic [1:0]  frame_end_in,
  input  wire logic [9:0]  frame_status_in,
  input  wire logic [1:0]  rx_ready_in,
  input  wire logic [1:0]  tx_ready_in,
  input  wire logic        irq_pending_in,
  input  wire logic        daisy_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [1:0]       wait_req_n_out,
  output logic [1:0]       tx_req_n_out,
  output logic [1:0]       crc_reset_out,
  output logic [1:0]       rx_lock_out,
  output logic             under_service_latch_out
);
  // Registered state of the block, apart from the FIFO memory
  typedef struct packed {
    logic [7:0]                   pointer_command_reg;
    logic [1:0][7:0]              irq_dma_ctrl_reg;
    logic [7:0]                   vector_reg;
    logic [7:0]                   master_irq_ctrl_reg;
    logic [1:0][7:0]              ext_status_ctrl_reg;
    logic [1:0][7:0]              sdlc_enh_reg;
    logic [1:0][7:0]              flag_reg;
    logic [1:0][7:0]              data_reg;
    logic [1:0][`SCHP_CNT_W-1:0]  byte_cnt;
    logic [1:0][3:0]              wr_ptr;
    logic [1:0][3:0]              rd_ptr;
    logic [1:0][3:0]              fill;
    logic [1:0]                   overflow;
    logic [1:0]                   stat_locked;
    logic [1:0]                   eof_lock;
    logic [1:0][1:0]              rx_sync;
    logic [1:0]                   rx_seen;
    schp_pkg::schp_phase_type     phase;
    logic [2:0]                   rec_cnt;
    logic                         under_service;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic [1:0]                   wait_req_n;
    logic [1:0]                   tx_req_n;
    logic [1:0]                   crc_reset;
  } schp_state_type;

  schp_state_type state;       // Current state
  schp_state_type next_state;  // Next state
  schp_pkg::schp_entry_type fifo_mem [2][`SCHP_FIFO_DEPTH];  // Frame status storage
  schp_pkg::schp_req_type   req;   // Decoded request fields
  logic                     fifo_on [2];  // FIFO mode active per channel
  logic                     access;       // APB access phase
  logic [3:0]               reg_code;     // Indirect register code

  // Request carrier from the bus word
  assign req = '{write: paddr_in == `SCHP_ADDR_BUS && pwrite_in, chan_a: pwdata_in[8],
                 data_sel: pwdata_in[9], ack: pwdata_in[10], wdata: pwdata_in[7:0]};
  assign access = psel_in && penable_in && !state.pready;
  // Point high only when bit 3 set and bits 5,6 clear
  assign reg_code = {state.pointer_command_reg[3] && state.pointer_command_reg[6:5] == 2'b00,
                     state.pointer_command_reg[2:0]};

  // FIFO memory is written per channel on frame end
  for (genvar c = 0; c < 2; c++) begin : g_fifo
    assign fifo_on[c] = state.ext_status_ctrl_reg[c][`SCHP_EXT_FIFO_BIT] && sdlc_mode_in[c];
    always_ff @(posedge clk_in) begin
      if (fifo_on[c] && frame_end_in[c] && state.fill[c] != 4'(`SCHP_FIFO_DEPTH)) begin
        fifo_mem[c][state.wr_ptr[c]] <= '{count: state.byte_cnt[c], status: frame_status_in[c*5 +: 5]};
      end
    end
  end

  // Read mux for one indirect read; channel index 1 is A
  function automatic logic [7:0] schp_read(input int ch, input logic [3:0] code, input logic ack_cyc);
    logic [7:0] v;
    logic       fe;
    schp_pkg::schp_entry_type e;
    v = 8'h00;
    fe = fifo_on[ch] && state.fill[ch] != 4'h0;
    e = fifo_mem[ch][state.rd_ptr[ch]];
    case (code)
      4'h0, 4'h4: v = {5'h00, tx_ready_in[ch], 1'b0, rx_ready_in[ch]};
      4'h1, 4'h5: v = fe ? {1'b1, 1'b0, 1'b0, e.status[4:3], e.status[2:0]}
                          : {1'b0, 6'h00, 1'b1};
      4'h2: v = (ch == 1) ? state.vector_reg : {state.vector_reg[7:4], irq_pending_in, state.vector_reg[2:0]};
      // Without the FIFO this position mirrors the vector read, status included on B
      4'h6: v = fifo_on[ch] ? e.count[7:0] :
                ((ch == 1) ? state.vector_reg : {state.vector_reg[7:4], irq_pending_in, state.vector_reg[2:0]});
      4'h7: v = fifo_on[ch] ? {state.overflow[ch], fe, e.count[13:8]} : 8'h00;
      4'h8: v = state.data_reg[ch];
      4'hB, 4'hF: v = state.ext_status_ctrl_reg[ch];
      4'hA, 4'hE: v = state.flag_reg[ch];
      default: v = 8'h00;
    endcase
    return ack_cyc ? state.vector_reg : v;
  endfunction

  // Next-state logic
  always_comb begin
    int ch;
    logic [3:0] code;
    logic pop;
    next_state = state;
    ch = req.chan_a ? 1 : 0;
    code = req.data_sel ? 4'h8 : reg_code;
    pop = 1'b0;
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    next_state.crc_reset = 2'b00;
    if (state.phase == schp_pkg::SCHP_REC) begin
      next_state.rec_cnt = state.rec_cnt - 3'd1;
      if (state.rec_cnt == 3'd1) next_state.phase = schp_pkg::SCHP_IDLE;
    end
    // Bus access: strobe only effective while selected
    if (access && psel_in) begin
      next_state.pready = 1'b1;
      next_state.prdata = 32'h0000_0000;
      if (paddr_in != `SCHP_ADDR_BUS) begin
        next_state.pslverr = 1'b1;
      end else if (req.ack && !pwrite_in) begin
        if (irq_pending_in && daisy_in) begin
          next_state.prdata = {24'h00_0000, state.vector_reg};
          next_state.under_service = 1'b1;
        end
      end else if (pwrite_in) begin
        if (req.data_sel) next_state.data_reg[ch] = req.wdata;
        else if (code == 4'h0) next_state.pointer_command_reg = req.wdata;
        else begin
          case (code)
            `SCHP_REG_IRQDMA: next_state.irq_dma_ctrl_reg[ch] = req.wdata;
            `SCHP_REG_VECTOR: next_state.vector_reg = req.wdata;
            `SCHP_REG_MASTER: next_state.master_irq_ctrl_reg = req.wdata;
            `SCHP_REG_EXT: next_state.ext_status_ctrl_reg[ch] = req.wdata;
            `SCHP_REG_FLAG: begin
              if (state.ext_status_ctrl_reg[ch][`SCHP_EXT_ENH_BIT]) next_state.sdlc_enh_reg[ch] = req.wdata;
              else next_state.flag_reg[ch] = req.wdata;
            end
            default: ;
          endcase
        end
      end else begin
        next_state.prdata = {24'h00_0000, schp_read(ch, code, 1'b0)};
        if (code == 4'h1 && fifo_on[ch]) pop = state.fill[ch] != 4'h0 && !state.stat_locked[ch];
        if (code == 4'h7) next_state.stat_locked[ch] = 1'b0;
      end
      if (!req.data_sel && state.pointer_command_reg[4:0] != 5'h00 && paddr_in == `SCHP_ADDR_BUS)
        next_state.pointer_command_reg[4:0] = 5'h00;
      next_state.phase = schp_pkg::SCHP_REC;
      next_state.rec_cnt = 3'(`SCHP_RECOVERY_CYC);
    end
    // Per channel FIFO and stall line upkeep
    for (int c = 0; c < 2; c++) begin
      next_state.rx_sync[c] = {state.rx_sync[c][0], rx_byte_in[c]};
      next_state.rx_seen[c] = state.rx_sync[c][1];
      if (!fifo_on[c]) begin
        next_state.wr_ptr[c] = 4'h0;
        next_state.rd_ptr[c] = 4'h0;
        next_state.fill[c] = 4'h0;
        next_state.byte_cnt[c] = '0;
        if (!state.ext_status_ctrl_reg[c][`SCHP_EXT_FIFO_BIT]) next_state.overflow[c] = 1'b0;
      end else begin
        if (state.rx_sync[c][1] && !state.rx_seen[c]) next_state.byte_cnt[c] = state.byte_cnt[c] + 1'b1;
        if (frame_end_in[c]) begin
          next_state.byte_cnt[c] = '0;
          if (state.fill[c] == 4'(`SCHP_FIFO_DEPTH)) next_state.overflow[c] = 1'b1;
          else begin
            next_state.wr_ptr[c] = (state.wr_ptr[c] == 4'(`SCHP_FIFO_DEPTH - 1)) ? 4'h0 : state.wr_ptr[c] + 4'h1;
            next_state.fill[c] = next_state.fill[c] + 4'h1;
          end
        end
        if (pop && ch == c) begin
          next_state.rd_ptr[c] = (state.rd_ptr[c] == 4'(`SCHP_FIFO_DEPTH - 1)) ? 4'h0 : state.rd_ptr[c] + 4'h1;
          next_state.fill[c] = next_state.fill[c] - 4'h1;
          next_state.stat_locked[c] = next_state.fill[c] == 4'h0;
        end
      end
      if (frame_end_in[c]) next_state.crc_reset[c] = 1'b1;
      // End of frame locks data FIFO only in legacy special modes
      next_state.eof_lock[c] = !fifo_on[c] && frame_end_in[c] && state.irq_dma_ctrl_reg[c][4:3] != 2'b10
                               && state.irq_dma_ctrl_reg[c][4:3] != 2'b00 ? 1'b1 :
                               (fifo_on[c] ? 1'b0 : state.eof_lock[c]);
      // Wait mode asserts when not ready, request mode when ready
      if (!state.irq_dma_ctrl_reg[c][`SCHP_WREQ_EN_BIT]) next_state.wait_req_n[c] = 1'b1;
      else if (state.irq_dma_ctrl_reg[c][`SCHP_WREQ_FUNC_BIT])
        next_state.wait_req_n[c] = !(state.irq_dma_ctrl_reg[c][`SCHP_WREQ_RX_BIT] ? rx_ready_in[c] : tx_ready_in[c]);
      else
        next_state.wait_req_n[c] = state.irq_dma_ctrl_reg[c][`SCHP_WREQ_RX_BIT] ? rx_ready_in[c] : tx_ready_in[c];
      next_state.tx_req_n[c] = !(state.sdlc_enh_reg[c][`SCHP_DREQ_BIT] && tx_ready_in[c]);
    end
    if (!irq_pending_in) next_state.under_service = 1'b0;
  end

  // State register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= '0;
      state.wait_req_n <= 2'b11;
      state.tx_req_n <= 2'b11;
    end else begin
      state <= next_state;
    end
  end

  assign prdata_out = state.prdata;
  assign pready_out = state.pready;
  assign pslverr_out = state.pslverr;
  assign wait_req_n_out = state.wait_req_n;
  assign tx_req_n_out = state.tx_req_n;
  assign crc_reset_out = state.crc_reset;
  assign rx_lock_out = state.eof_lock;
  assign under_service_latch_out = state.under_service;

  // Checks on the port behaviour
  a_ptr_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    access && !req.data_sel && !pwrite_in && paddr_in == `SCHP_ADDR_BUS
    |=> state.pointer_command_reg[4:0] == 5'h00) else $error("pointer not cleared");
  a_fifo_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !fifo_on[0] |=> state.fill[0] == 4'h0) else $error("fifo not reset");
  a_fill_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state.fill[1] <= 4'd10) else $error("fifo overfill");
  a_crc_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame_end_in[1] |=> crc_reset_out[1]) else $error("crc not reset");
  a_ovf_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state.overflow[0] && fifo_on[0] |=> state.overflow[0]) else $error("overflow lost");
  a_ready_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pready_out |=> !pready_out) else $error("ready stuck");
  a_iack_latch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    access && req.ack && !pwrite_in && irq_pending_in && daisy_in && paddr_in == 12'h000
    |=> under_service_latch_out) else $error("service latch not set");
  a_lock_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fifo_on[0] |=> !rx_lock_out[0]) else $error("lock in fifo mode");
  c_pop: cover property (@(posedge clk_in) state.fill[0] == 4'h1 ##1 state.fill[0] == 4'h0);
  c_full: cover property (@(posedge clk_in) state.fill[1] == 4'd10);
  c_ack: cover property (@(posedge clk_in) under_service_latch_out);
endmodule

// *** schp_top_tb.sv ***
// Self-checking bench for the host port and frame status FIFO
`timescale 1ns/100ps
`include "schp_regs.svh"
module schp_top_tb;
  logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, irq_pending_in, daisy_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic [1:0] sdlc_mode_in, rx_byte_in, frame_end_in, rx_ready_in, tx_ready_in;
  logic [9:0] frame_status_in;
  logic pready_out, pslverr_out, under_service_latch_out;
  logic [1:0] wait_req_n_out, tx_req_n_out, crc_reset_out, rx_lock_out;
  logic [7:0] v;
  logic e;
  int mismatches, comparisons, crc_seen;
  schp_top schp_top_inst (.clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .sdlc_mode_in, .rx_byte_in, .frame_end_in, .frame_status_in, .rx_ready_in,
    .tx_ready_in, .irq_pending_in, .daisy_in, .prdata_out, .pready_out, .pslverr_out,
    .wait_req_n_out, .tx_req_n_out, .crc_reset_out, .rx_lock_out, .under_service_latch_out);
  schp_host_model schp_host_model_inst (.clk_in, .prdata_in(prdata_out), .pready_in(pready_out),
    .pslverr_in(pslverr_out), .psel_out(psel_in), .penable_out(penable_in),
    .pwrite_out(pwrite_in), .paddr_out(paddr_in), .pwdata_out(pwdata_in));
  // Clock at 10 ns
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Count checker reset pulses of channel A
  always @(posedge clk_in) begin
    if (crc_reset_out[1] === 1'b1) crc_seen++;
  end
  // Byte compare; flags are passed zero-extended
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pointer write, then the access it selects
  task automatic wreg(input logic a, input logic [7:0] code, input logic [7:0] val);
    schp_host_model_inst.xfer(1'b1, `SCHP_ADDR_BUS, {2'b00, a, code}, v, e);
    schp_host_model_inst.xfer(1'b1, `SCHP_ADDR_BUS, {2'b00, a, val}, v, e);
  endtask
  task automatic rreg(input logic a, input logic [7:0] code);
    schp_host_model_inst.xfer(1'b1, `SCHP_ADDR_BUS, {2'b00, a, code}, v, e);
    schp_host_model_inst.xfer(1'b0, `SCHP_ADDR_BUS, {2'b00, a, 8'h00}, v, e);
  endtask
  // One received frame of n bytes closed by a flag on channel A
  task automatic frame(input int n);
    repeat (n) begin
      @(posedge clk_in) rx_byte_in <= 2'b10;
      repeat (3) @(posedge clk_in);
      rx_byte_in <= 2'b00;
      repeat (3) @(posedge clk_in);
    end
    frame_end_in <= 2'b10;
    @(posedge clk_in);
    frame_end_in <= 2'b00;
    repeat (4) @(posedge clk_in);
  endtask
  // Readback, shared vector, pointer self-clear, unmapped word
  task automatic t_regs;
    rreg(1'b1, 8'h0F);
    check8(v & 8'h04, 8'h00);
    wreg(1'b0, 8'h02, 8'hA5);
    rreg(1'b1, 8'h02);
    check8(v, 8'hA5);
    // A stray write now lands on the pointer, not the vector
    schp_host_model_inst.xfer(1'b1, `SCHP_ADDR_BUS, 11'h400, v, e);
    rreg(1'b1, 8'h02);
    check8(v, 8'hA5);
    schp_host_model_inst.xfer(1'b0, `SCHP_ADDR_RDATA, 11'h000, v, e);
    check8({7'h00, e}, 8'h01);
    $display("TB: regs done");
  endtask
  // Acknowledge cycles with the chain closed, then open
  task automatic t_ack;
    irq_pending_in <= 1'b1;
    schp_host_model_inst.xfer(1'b0, `SCHP_ADDR_BUS, 11'h500, v, e);
    check8({7'h00, under_service_latch_out}, 8'h00);
    daisy_in <= 1'b1;
    schp_host_model_inst.xfer(1'b0, `SCHP_ADDR_BUS, 11'h500, v, e);
    check8(v, 8'hA5);
    check8({7'h00, under_service_latch_out}, 8'h01);
    irq_pending_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check8({7'h00, under_service_latch_out}, 8'h00);
    $display("TB: ack done");
  endtask
  // Request mode then wait mode, ready and not ready each
  task automatic t_wreq;
    for (int i = 0; i < 4; i++) begin
      if (i % 2 == 0) wreg(1'b1, 8'h01, (i < 2) ? 8'hE0 : 8'hA0);
      rx_ready_in <= {i[0], 1'b0};
      repeat (4) @(posedge clk_in);
      check8({7'h00, wait_req_n_out[1]}, {7'h00, i[0] ^ (i < 2)});
      check8({7'h00, wait_req_n_out[0]}, 8'h01);
    end
    wreg(1'b1, 8'h0F, 8'h05);
    wreg(1'b1, 8'h07, 8'h10);
    tx_ready_in <= 2'b10;
    repeat (4) @(posedge clk_in);
    check8({6'h00, tx_req_n_out}, 8'h01);
    rreg(1'b1, 8'h0F);
    check8(v & 8'h04, 8'h04);
    $display("TB: wait request done");
  endtask
  // Eleven frames overrun ten entries; pop, then toggle enable
  task automatic t_fifo;
    frame(3);
    repeat (10) frame(0);
    check8(crc_seen[7:0], 8'd11);
    rreg(1'b1, 8'h07);
    check8(v & 8'hC0, 8'hC0);
    rreg(1'b1, 8'h06);
    check8(v, 8'h03);
    rreg(1'b1, 8'h01);
    rreg(1'b1, 8'h07);
    rreg(1'b1, 8'h06);
    check8(v, 8'h00);
    wreg(1'b1, 8'h0F, 8'h01);
    wreg(1'b1, 8'h0F, 8'h05);
    rreg(1'b1, 8'h07);
    check8(v & 8'hC0, 8'h00);
    $display("TB: fifo done");
  endtask
  task automatic conclude;
    $display("TB: %0d compares, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    mismatches++;
    conclude;
  end
  // Main sequence
  initial begin
    {rst_n_in, irq_pending_in, daisy_in, rx_byte_in, frame_end_in} = '0;
    {rx_ready_in, tx_ready_in, frame_status_in} = '0;
    sdlc_mode_in = 2'b10;
    {mismatches, comparisons, crc_seen} = '0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_ack;
    t_wreq;
    t_fifo;
    conclude;
  end
endmodule
